/* logic/dcd_dev.sv */
`include "dcd_regs.svh"
// device end: decodes pins, keeps mode registers, queues operations
module dcd_dev (
  input  wire logic               clk,
  input  wire logic               reset_n,
  input  wire logic               reset,
  dcd_if.dev                      pins,
  output logic                    op_valid,
  input  wire logic               op_ready,
  output dcd_pkg::dcd_cmd_t       op_cmd,
  output dcd_pkg::dcd_addr_t      op_addr,
  output dcd_pkg::dcd_bmap_t      op_banks,
  output dcd_pkg::dcd_data_t      op_data,
  output dcd_pkg::dcd_mask_t      op_keep,
  output logic                    cmd_stall,
  output dcd_pkg::dcd_addr_t      mode_zero,
  output dcd_pkg::dcd_addr_t      mode_one,
  output dcd_pkg::dcd_addr_t      mode_two
);
  import dcd_pkg::*;
  localparam int OPW = 3 + `DCD_ADDR_W + `DCD_NBANK + `DCD_DATA_W +
                       `DCD_MASK_W;
  dcd_addr_t mode_reg_zero_ff;
  dcd_addr_t mode_reg_one_ff;
  dcd_addr_t mode_reg_two_ff;
  dcd_cmd_t  cmd;
  dcd_bmap_t banks;
  dcd_addr_t eff_addr;
  logic [1:0] wmode;
  logic [1:0] bl;
  logic      fifo_ready;
  logic [OPW-1:0] fifo_out;
  // decode from pins sampled this edge
  always_comb begin                                                  // RL1
    if (pins.cs_n) begin
      cmd = DCD_NOP;                                                 // RL2
    end else begin
      unique case ({pins.we_n, pins.ref_n})                         // RL3
        2'b00:   cmd = DCD_MRS;
        2'b11:   cmd = DCD_RD;
        2'b01:   cmd = DCD_WR;
        default: cmd = DCD_REF;
      endcase
    end
  end
  assign wmode = mode_reg_two_ff[`DCD_MR2_WB_MSB:`DCD_MR2_WB_LSB];   // RL10
  assign bl    = mode_reg_one_ff[`DCD_MR1_BL_MSB:`DCD_MR1_BL_LSB];
  // longer bursts drop low address bits, wide config clears the top address bit
  always_comb begin                                                  // RL17
    eff_addr = pins.addr;
    if (cmd == DCD_RD || cmd == DCD_WR) begin
      if (mode_reg_zero_ff[`DCD_MR0_WIDE_BIT]) begin
        eff_addr[`DCD_ADDR_W-1] = 1'b0;
      end
      if (bl != 2'h0) begin
        eff_addr = eff_addr >> bl;
      end
    end
  end
  always_comb begin
    banks = '0;
    unique case (cmd)
      DCD_RD: banks[pins.bank] = 1'b1;                               // RL9
      DCD_WR: begin                                                  // RL11
        for (int i = 0; i < `DCD_NBANK; i++) begin
          unique case (wmode)
            2'h1:    banks[i] = (i[2:0] == pins.bank[2:0]);
            2'h2:    banks[i] = (i[1:0] == pins.bank[1:0]);
            default: banks[i] = (i[3:0] == pins.bank);
          endcase
        end
      end
      DCD_REF: begin                                                 // RL13
        if (mode_reg_two_ff[`DCD_MR2_RMODE_BIT]) begin
          banks[`DCD_NBANK-1:0] = pins.addr[`DCD_NBANK-1:0];         // RL16
          for (int i = 0, n = 0; i < `DCD_NBANK; i++) begin          // RL14
            if (banks[i]) begin
              n++;
              if (n > 4) banks[i] = 1'b0;
            end
          end
        end else begin
          banks[pins.bank] = 1'b1;                                   // RL16
        end
      end
      default: banks = '0;
    endcase
  end
  always_ff @(posedge clk) begin
    if (!reset_n) begin                                              // RL6
      mode_reg_zero_ff <= `DCD_MR_RESET;
      mode_reg_one_ff  <= `DCD_MR_RESET;
      mode_reg_two_ff  <= `DCD_MR_RESET;
    end else if (cmd == DCD_MRS) begin
      unique case (pins.bank[1:0])                                   // RL5
        2'h0:    mode_reg_zero_ff <= pins.addr;                      // RL4
        2'h1:    mode_reg_one_ff  <= pins.addr;
        2'h2:    mode_reg_two_ff  <= pins.addr;
        default: mode_reg_two_ff  <= mode_reg_two_ff;
      endcase
    end
  end
  assign mode_zero = mode_reg_zero_ff;
  assign mode_one  = mode_reg_one_ff;
  assign mode_two  = mode_reg_two_ff;
  assign cmd_stall = !fifo_ready;
  dcd_fifo #(
    .WIDTH (OPW),
    .DEPTH (`DCD_FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .reset     (reset),
    .in_valid  (cmd == DCD_RD || cmd == DCD_WR || cmd == DCD_REF), // RL15
    .in_ready  (fifo_ready),
    .in_data   ({cmd, eff_addr, banks, pins.wdata,
                 (cmd == DCD_WR) ? ~pins.write_mask : 2'h0}),        // RL12
    .out_valid (op_valid),
    .out_ready (op_ready),
    .out_data  (fifo_out)
  );
  assign op_cmd   = dcd_cmd_t'(fifo_out[OPW-1 -: 3]);
  assign op_addr  = fifo_out[OPW-4 -: `DCD_ADDR_W];
  assign op_banks = fifo_out[OPW-4-`DCD_ADDR_W -: `DCD_NBANK];
  assign op_data  = fifo_out[`DCD_DATA_W+`DCD_MASK_W-1 -: `DCD_DATA_W];
  assign op_keep  = fifo_out[`DCD_MASK_W-1:0];
endmodule : dcd_dev

/* logic/dcd_regs.svh */
`ifndef DCD_REGS_SVH
`define DCD_REGS_SVH
// How it works
// RL1 - commands captured on rising clock edge
// RL2 - no-op starts nothing, work continues
// RL3 - chip select and strobes encode commands
// RL4 - mode set stores address as contents
// RL5 - bank bits 1:0 pick mode register
// RL6 - mode registers hold until rewrite or reset
// RL7 - mode set only when all idle
// RL8 - wait settle interval after mode set
// RL9 - read uses bank and address inputs
// RL10 - mode_reg_two bits 4:3 pick write width
// RL11 - write decodes 4, 3 or 2 bank bits
// RL12 - masked-high write data is discarded
// RL13 - refresh per bank or multibank
// RL14 - multibank refresh covers up to four banks
// RL15 - each refresh command acts once
// RL16 - refresh uses bank or address lines
// RL17 - address width follows burst and width
// RL18 - wait row cycle count per bank
`define DCD_ADDR_W        20
`define DCD_BANK_W        4
`define DCD_NBANK         16
`define DCD_DATA_W        36
`define DCD_MASK_W        2
`define DCD_MR_RESET      20'h00000
`define DCD_MR0_RC_LSB    0
`define DCD_MR0_RC_MSB    3
`define DCD_MR2_WB_LSB    3
`define DCD_MR2_WB_MSB    4
`define DCD_MR2_RMODE_BIT 5
`define DCD_MR1_BL_LSB    3
`define DCD_MR1_BL_MSB    4
`define DCD_MR0_WIDE_BIT  10
`define DCD_SETTLE_NS     96
`define DCD_CLK_NS        8
`define DCD_SETTLE_CYC    ((`DCD_SETTLE_NS + `DCD_CLK_NS - 1) / `DCD_CLK_NS)
`define DCD_FIFO_DEPTH    4
`endif

/* logic/dcd_pkg.sv */
`include "dcd_regs.svh"
package dcd_pkg;
  typedef enum logic [2:0] {
    DCD_NOP  = 3'h0,
    DCD_MRS  = 3'h1,
    DCD_RD   = 3'h3,
    DCD_WR   = 3'h2,
    DCD_REF  = 3'h6
  } dcd_cmd_t;
  typedef logic [`DCD_ADDR_W-1:0] dcd_addr_t;
  typedef logic [`DCD_BANK_W-1:0] dcd_bank_t;
  typedef logic [`DCD_NBANK-1:0]  dcd_bmap_t;
  typedef logic [`DCD_DATA_W-1:0] dcd_data_t;
  typedef logic [`DCD_MASK_W-1:0] dcd_mask_t;
  typedef enum logic [1:0] {
    DCD_IDLE   = 2'h0,
    DCD_ISSUE  = 2'h1,
    DCD_SETTLE = 2'h3
  } dcd_hst_t;
endpackage : dcd_pkg

/* logic/dcd_if.sv */
interface dcd_if (
  input wire logic clk
);
  import dcd_pkg::*;
  logic      cs_n;
  logic      we_n;
  logic      ref_n;
  dcd_addr_t addr;
  dcd_bank_t bank;
  dcd_data_t wdata;
  dcd_mask_t write_mask;
  modport ctrl (
    output cs_n, we_n, ref_n, addr, bank, wdata, write_mask
  );
  modport dev (
    input cs_n, we_n, ref_n, addr, bank, wdata, write_mask
  );
endinterface : dcd_if

/* logic/dcd_fifo.sv */
module dcd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ff;
  logic [AW-1:0]    rd_ff;
  logic [AW:0]      cnt_ff;
  logic             push;
  logic             pop;
  assign in_ready  = (cnt_ff != (AW+1)'(DEPTH));
  assign out_valid = (cnt_ff != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_ff[rd_ff];
  always_ff @(posedge clk) begin
    if (push) begin
      mem_ff[wr_ff] <= in_data;
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) begin
        wr_ff <= (wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + 1'b1;
      end
      if (pop) begin
        rd_ff <= (rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + 1'b1;
      end
      cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : dcd_fifo

/* logic/dcd_ctrl.sv */
`include "dcd_regs.svh"
// controller end: turns user requests into pin commands
module dcd_ctrl (
  input  wire logic              clk,
  input  wire logic              reset,
  dcd_if.ctrl                    pins,
  input  wire logic              req_valid,
  output logic                   req_ready,
  input  wire dcd_pkg::dcd_cmd_t req_cmd,
  input  wire dcd_pkg::dcd_addr_t req_addr,
  input  wire dcd_pkg::dcd_bank_t req_bank,
  input  wire dcd_pkg::dcd_data_t req_data,
  input  wire dcd_pkg::dcd_mask_t req_mask,
  input  wire logic [3:0]        row_cycles,
  input  wire logic              all_idle,
  output logic                   busy
);
  import dcd_pkg::*;
  dcd_hst_t          st_ff;
  logic [7:0]        wait_ff;
  logic [3:0]        bank_cnt_ff [`DCD_NBANK];
  logic              bank_ok;
  logic              mrs_ok;
  logic              go;
  assign bank_ok = (bank_cnt_ff[req_bank] == 4'h0);                  // RL18
  assign mrs_ok  = all_idle;                                         // RL7
  assign go = req_valid && (st_ff == DCD_IDLE) &&
              ((req_cmd == DCD_MRS) ? mrs_ok :
               (req_cmd == DCD_NOP) ? 1'b1 : bank_ok);
  assign req_ready = go;
  assign busy = (st_ff != DCD_IDLE);
  always_ff @(posedge clk) begin
    if (reset) begin
      pins.cs_n       <= 1'b1;
      pins.we_n       <= 1'b1;
      pins.ref_n      <= 1'b1;
      pins.addr       <= '0;
      pins.bank       <= '0;
      pins.wdata      <= '0;
      pins.write_mask <= '1;
    end else if (go && req_cmd != DCD_NOP) begin
      pins.cs_n       <= 1'b0;                                       // RL3
      pins.we_n       <= !(req_cmd == DCD_MRS || req_cmd == DCD_WR);
      pins.ref_n      <= !(req_cmd == DCD_MRS || req_cmd == DCD_REF);
      pins.addr       <= req_addr;
      pins.bank       <= req_bank;
      pins.wdata      <= req_data;
      pins.write_mask <= req_mask;
    end else begin
      pins.cs_n  <= 1'b1;                                            // RL15
      pins.we_n  <= 1'b1;
      pins.ref_n <= 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      st_ff   <= DCD_IDLE;
      wait_ff <= '0;
    end else begin
      unique case (st_ff)
        DCD_IDLE: begin
          if (go && req_cmd == DCD_MRS) begin
            st_ff   <= DCD_SETTLE;
            wait_ff <= 8'(`DCD_SETTLE_CYC);                         // RL8
          end
        end
        DCD_SETTLE: begin
          if (wait_ff <= 8'h01) begin
            st_ff <= DCD_IDLE;
          end
          wait_ff <= wait_ff - 8'h01;
        end
        default: st_ff <= DCD_IDLE;
      endcase
    end
  end
  for (genvar b = 0; b < `DCD_NBANK; b++) begin : g_bank
    always_ff @(posedge clk) begin
      if (reset) begin
        bank_cnt_ff[b] <= 4'h0;
      end else if (go && req_bank == b &&
                   (req_cmd == DCD_RD || req_cmd == DCD_WR ||
                    req_cmd == DCD_REF)) begin
        bank_cnt_ff[b] <= row_cycles;                                // RL18
      end else if (bank_cnt_ff[b] != 4'h0) begin
        bank_cnt_ff[b] <= bank_cnt_ff[b] - 4'h1;
      end
    end
  end
endmodule : dcd_ctrl

/* dv/dcd_props.sv */
module dcd_props (
  input wire logic       clk,
  input wire logic       reset,
  input wire logic       cs_n,
  input wire logic       we_n,
  input wire logic       ref_n,
  input wire logic [3:0] bank,
  input wire logic [1:0] write_mask,
  input wire logic [3:0] row_cycles,
  input wire logic       all_idle
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic       mode_set_cmd, rd, wr, rf, same;
  logic [3:0] quiet_ff, age_ff, last_ff;
  assign mode_set_cmd = !cs_n && !we_n && !ref_n;
  assign rd = !cs_n && we_n && ref_n;
  assign wr = !cs_n && !we_n && ref_n;
  assign rf = !cs_n && we_n && !ref_n;
  assign same = bank == last_ff && age_ff < row_cycles;
  // settle countdown after a mode set
  always_ff @(posedge clk)
    if (reset) quiet_ff <= 4'h0;
    else if (mode_set_cmd) quiet_ff <= 4'hB;
    else if (quiet_ff != 4'h0) quiet_ff <= quiet_ff - 4'h1;
  // cycles since the last bank access
  always_ff @(posedge clk)
    if (reset) age_ff <= 4'hF;
    else if (rd || wr || rf) age_ff <= 4'h1;
    else if (age_ff != 4'hF) age_ff <= age_ff + 4'h1;
  always_ff @(posedge clk)
    if (rd || wr || rf) last_ff <= bank;
  a_settle_quiet: assert property (quiet_ff != 4'h0 |-> cs_n)
    else $error("command inside settle time");
  a_settle_first: assert property (mode_set_cmd |=> cs_n [*8])
    else $error("command right after mode set");
  a_mrs_idle: assert property (mode_set_cmd |-> $past(all_idle))
    else $error("mode set while not idle");
  a_reset_idle: assert property ($fell(reset) |-> cs_n && &write_mask)
    else $error("pins not idle after reset");
  a_rd_gap: assert property (rd |-> !same)
    else $error("read inside row cycle");
  a_wr_gap: assert property (wr |-> !same)
    else $error("write inside row cycle");
  a_ref_gap: assert property (rf |-> !same)
    else $error("refresh inside row cycle");
  a_ref_once: assert property (rf && row_cycles != 4'h0 |=>
    !(rf && $stable(bank)))
    else $error("refresh repeated");
  c_mrs: cover property (mode_set_cmd);
  c_part_wr: cover property (wr && ^write_mask);
  c_ref_rd: cover property (rf ##1 rd);
endmodule : dcd_props

/* dv/dcd_tb.sv */
module dram_command_decoder_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import dcd_pkg::*;
  typedef struct {
    dcd_cmd_t c; dcd_addr_t a; dcd_bmap_t b; dcd_data_t d; dcd_mask_t k;
    int n;
  } dcd_exp_t;
  logic clk = 0, reset = 1, reset_n = 0, req_valid = 0, all_idle = 1;
  logic op_ready = 0, stall_all = 0, req_ready, busy, op_valid, cmd_stall;
  dcd_cmd_t  req_cmd = DCD_NOP, op_cmd;
  dcd_addr_t req_addr = '0, op_addr, m0, m1, m2, mr2 = '0;
  dcd_bank_t req_bank = '0;
  dcd_data_t req_data = '0, op_data;
  dcd_mask_t req_mask = '0, op_keep;
  dcd_bmap_t op_banks;
  logic [15:0] lf_ff = 16'h0017;
  int fail_count = 0, checked = 0, lim = 2, i;
  dcd_exp_t q[$], e;
  dcd_cmd_t kinds[4] = '{DCD_NOP, DCD_RD, DCD_WR, DCD_REF};
  always #4 clk = ~clk;
  dcd_if pins_if (.clk(clk));
  dcd_ctrl dcd_ctrl_inst (.clk(clk), .reset(reset), .pins(pins_if),
    .req_valid(req_valid), .req_ready(req_ready), .req_cmd(req_cmd),
    .req_addr(req_addr), .req_bank(req_bank), .req_data(req_data),
    .req_mask(req_mask), .row_cycles(4'h3), .all_idle(all_idle),
    .busy(busy));
  dcd_dev dcd_dev_inst (.clk(clk), .reset_n(reset_n), .reset(reset),
    .pins(pins_if), .op_valid(op_valid), .op_ready(op_ready),
    .op_cmd(op_cmd), .op_addr(op_addr), .op_banks(op_banks),
    .op_data(op_data), .op_keep(op_keep), .cmd_stall(cmd_stall),
    .mode_zero(m0), .mode_one(m1), .mode_two(m2));
  dcd_props dcd_props_inst (.clk(clk), .reset(reset), .cs_n(pins_if.cs_n),
    .we_n(pins_if.we_n), .ref_n(pins_if.ref_n), .bank(pins_if.bank),
    .write_mask(pins_if.write_mask), .row_cycles(4'h3),
    .all_idle(all_idle));
  function logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task chk(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task stop_test;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test
  task send(input dcd_cmd_t c, input dcd_bank_t b, input dcd_addr_t a,
            input dcd_mask_t m);
    int n;
    dcd_exp_t x;
    n = 0;
    // keep the buffer from overflowing, and mode sets on an idle device
    do begin @(negedge clk); n++; end
    while ((q.size() > lim || (c == DCD_MRS && q.size() != 0)) && n < 500);
    x = '{c, a, 16'h1 << b, {lf_ff, lf_ff, lf_ff[3:0]}, '0, 0};
    @(posedge clk);
    req_cmd <= c; req_bank <= b; req_addr <= a; req_data <= x.d;
    req_mask <= m; req_valid <= 1'b1;
    do begin @(negedge clk); n++; end while (req_ready !== 1'b1 && n < 500);
    if (n >= 500) fail_count++;
    @(posedge clk);
    req_valid <= 1'b0;
    if (c == DCD_WR) x.k = ~m;
    if (c == DCD_WR && mr2[4:3] != 2'h0) x.n = mr2[4:3] == 2'h1 ? 2 : 4;
    if (c == DCD_REF && mr2[5]) x.b = a[15:0];
    if (c == DCD_MRS && b == 4'h2) mr2 = a;
    if (c != DCD_NOP && c != DCD_MRS) q.push_back(x);
  endtask : send
  always @(posedge clk) begin
    lf_ff <= lfsr(lf_ff);
    op_ready <= !stall_all && lf_ff[0];
  end
  always @(negedge clk)
    if (op_valid === 1'b1 && op_ready === 1'b1) begin
      if (q.size() == 0) chk(1, 0);
      else begin
        e = q.pop_front();
        chk(op_cmd, e.c);
        if (e.c != DCD_REF) chk(op_addr, e.a);
        if (e.n == 0) chk(op_banks, e.b);
        else chk($countones(op_banks), e.n);
        if (e.c == DCD_WR) chk(op_data, e.d);
        chk(op_keep, e.k);
      end
    end
  initial begin
    #400000;
    fail_count++;
    stop_test;
  end
  initial begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    reset_n <= 1'b1;
    send(DCD_MRS, 4'h0, 20'h00003, '0);
    send(DCD_MRS, 4'h1, 20'h5A007, '0);
    send(DCD_MRS, 4'h2, 20'h00000, '0);
    @(negedge clk);
    chk(busy, 1'b1);
    repeat (14) @(posedge clk);
    chk(m0, 20'h00003);
    chk(m1, 20'h5A007);
    chk(m2, 20'h00000);
    all_idle <= 1'b0;
    req_cmd <= DCD_MRS;
    req_valid <= 1'b1;
    @(negedge clk);
    chk(req_ready, 1'b0);
    @(posedge clk);
    req_valid <= 1'b0;
    all_idle <= 1'b1;
    for (i = 0; i < 60; i++)
      send(kinds[lf_ff[1:0]], lf_ff[5:2], {lf_ff, lf_ff[15:12]}, lf_ff[7:6]);
    // dual write, quad write, then multibank refresh
    foreach (kinds[j]) if (j > 0) begin
      send(DCD_MRS, 4'h2, 20'h00004 << j, '0);
      send(DCD_WR, lf_ff[3:0], 20'h00123, 2'h1);
      send(DCD_REF, 4'h5, 20'h00009, '0);
    end
    // drain first so four reads fill the buffer exactly
    for (i = 0; i < 200 && q.size() != 0; i++) @(posedge clk);
    stall_all <= 1'b1;
    lim = 4;
    for (i = 0; i < 4; i++) send(DCD_RD, i[3:0], 20'h00040, '0);
    repeat (3) @(posedge clk);
    chk(cmd_stall, 1'b1);
    stall_all <= 1'b0;
    for (i = 0; i < 200 && q.size() != 0; i++) @(posedge clk);
    @(negedge clk);
    chk(cmd_stall, 1'b0);
    reset_n <= 1'b0;
    @(posedge clk);
    reset_n <= 1'b1;
    @(negedge clk);
    chk(m0, 20'h00000);
    chk(m2, 20'h00000);
    stop_test;
  end
endmodule : dram_command_decoder_tb
